//--- verilog/ssrp_fifo.sv
// ssrp_fifo: small synchronous fifo with a registered head word.
// assumes one clock, synchronous active-high reset, and a power-of-two
// depth; both sides use valid/ready and stall each other honestly.
`timescale 1ns/1ns

module ssrp_fifo #(
    parameter int WIDTH = 15,
    parameter int DEPTH = 8
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // filling side
    input wire logic i_valid,
    input wire logic [WIDTH-1:0] i_data,
    output logic o_ready,
    // draining side
    output logic o_valid,
    output logic [WIDTH-1:0] o_data,
    input wire logic i_ready
);
    localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
            $error("ssrp_fifo depth must be a power of two, at least 2");
        end
        if (WIDTH < 1) begin : g_bad_width
            $error("ssrp_fifo width must be at least 1");
        end
    endgenerate

    // ************************************************************
    // state
    // ************************************************************
    typedef struct packed {
        logic [AW-1:0] wptr;
        logic [AW-1:0] rptr;
        logic [AW:0] cnt;
        logic head_valid;
        logic [WIDTH-1:0] head;
    } ssrp_fifo_st_t;

    ssrp_fifo_st_t q;
    ssrp_fifo_st_t d;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop_head;
    logic load;

    assign o_ready = (q.cnt != DEPTH[AW:0]);
    assign o_valid = q.head_valid;
    assign o_data = q.head;
    assign push = i_valid && o_ready;
    assign pop_head = q.head_valid && i_ready;
    // the head register refills from storage whenever it frees up
    assign load = (q.cnt != '0) && (!q.head_valid || pop_head);

    always_comb begin
        d = q;
        if (push) begin
            d.wptr = q.wptr + AW'(1);
        end
        if (load) begin
            d.rptr = q.rptr + AW'(1);
            d.head = mem[q.rptr];
            d.head_valid = 1'b1;
        end else if (pop_head) begin
            d.head_valid = 1'b0;
        end
        case ({push, load})
            2'b10: d.cnt = q.cnt + (AW+1)'(1);
            2'b01: d.cnt = q.cnt - (AW+1)'(1);
            default: d.cnt = q.cnt;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            q <= '0;
        end else begin
            q <= d;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (push) begin
            mem[q.wptr] <= i_data;
        end
    end

endmodule : ssrp_fifo

//--- verilog/ssrp_top.sv
// ssrp_pkg and ssrp_top: serial register port of a sensor, slave side.
// assumes the host drives chip select and serial clock as plain pins,
// sampled by i_mclk at 100 MHz; the register map sits outside and
// answers reads combinationally and drains writes through a fifo.

package ssrp_pkg;

    // ************************************************************
    // frame layout
    // ************************************************************
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam logic DIR_WRITE = 1'b0;
    localparam logic DIR_READ = 1'b1;
    localparam logic [2:0] LAST_BIT = 3'h7;
    localparam int DIR_POS = 6;

    // ************************************************************
    // defaults and timing
    // ************************************************************
    localparam logic [ADDR_W-1:0] FIFO_READOUT_ADDR_DEF = 7'h3f;
    localparam int WR_FIFO_DEPTH_DEF = 8;
    localparam int MCLK_MHZ = 100;
    localparam int CSB_IDLE_NS = 1000;
    localparam int CSB_IDLE_CYC = (CSB_IDLE_NS * MCLK_MHZ + 999) / 1000;

    typedef enum logic [1:0] {
        SSRP_IDLE,
        SSRP_CMD,
        SSRP_WDATA,
        SSRP_RDATA
    } ssrp_phase_t;

    typedef struct packed {
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } ssrp_wr_t;

    typedef struct packed {
        // pin synchronisers: first stage, second stage, then the previous second-stage value for edges
        logic cs_m;
        logic cs_s;
        logic cs_p;
        logic sck_m;
        logic sck_s;
        logic sck_p;
        logic din_m;
        logic din_s;
        // protocol
        ssrp_phase_t phase;
        logic [2:0] bitcnt;
        logic [DATA_W-1:0] in_sh;
        logic [DATA_W-1:0] out_sh;
        logic idle_high;
        // register side
        logic rd_req;
        logic rd_adv;
        logic [ADDR_W-1:0] rd_addr;
        logic [ADDR_W-1:0] wr_addr;
        logic pend_valid;
        ssrp_wr_t pend;
        logic overflow;
        // pins out
        logic dout;
        logic pad_oe_n;
        logic sdo_oe_n;
    } ssrp_core_t;

    // next read address: the fifo readout register never increments
    function automatic logic [ADDR_W-1:0] ssrp_next_addr(
        input logic [ADDR_W-1:0] a,
        input logic [ADDR_W-1:0] fifo_addr
    );
        logic [ADDR_W-1:0] r;
        r = (a == fifo_addr) ? a : a + 7'h01;
        return r;
    endfunction : ssrp_next_addr

endpackage : ssrp_pkg

`timescale 1ns/1ns

module ssrp_top #(
    parameter logic [6:0] FIFO_READOUT_ADDR = ssrp_pkg::FIFO_READOUT_ADDR_DEF,
    parameter int WR_FIFO_DEPTH = ssrp_pkg::WR_FIFO_DEPTH_DEF
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // serial link pins
    input wire logic i_csb_n,
    input wire logic i_sck,
    input wire logic i_bidir_data_pad,
    output logic o_bidir_data_pad,
    output logic o_bidir_data_pad_oe_n,
    output logic o_serial_out_pin,
    output logic o_serial_out_pin_oe_n,
    // configuration
    input wire logic i_three_wire_select,
    input wire logic i_overflow_clr,
    // status
    output logic o_frame_active,
    output logic o_clock_idle_high,
    output logic o_wr_overflow,
    // register read port
    output logic o_rd_req,
    output logic [6:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    // register write port
    output logic o_wr_valid,
    output ssrp_pkg::ssrp_wr_t o_wr,
    input wire logic i_wr_ready
);

    // ************************************************************
    // elaboration checks
    // ************************************************************
    generate
        if (WR_FIFO_DEPTH < 2) begin : g_bad_depth
            $error("ssrp_top write fifo depth must be at least 2");
        end
    endgenerate

    // ************************************************************
    // state and decode
    // ************************************************************
    ssrp_pkg::ssrp_core_t q;
    ssrp_pkg::ssrp_core_t d;
    logic fifo_in_ready;
    logic sck_rise;
    logic sck_fall;
    logic cs_fall;
    logic push_ok;
    logic [ssrp_pkg::DATA_W-1:0] byte_in;

    // edges are only ever taken from the second synchroniser stage
    assign sck_rise = q.sck_s && !q.sck_p;
    assign sck_fall = !q.sck_s && q.sck_p;
    assign cs_fall = q.cs_s && !q.cs_p;
    assign push_ok = q.pend_valid && fifo_in_ready;
    assign byte_in = {q.in_sh[6:0], q.din_s};

    // ************************************************************
    // next state
    // ************************************************************
    always_comb begin
        d = q;
        d.cs_m = !i_csb_n;
        d.cs_s = q.cs_m;
        d.cs_p = q.cs_s;
        d.sck_m = i_sck;
        d.sck_s = q.sck_m;
        d.sck_p = q.sck_s;
        d.din_m = i_bidir_data_pad;
        d.din_s = q.din_m;
        d.rd_req = 1'b0;
        d.rd_adv = 1'b0;

        if (push_ok) begin
            d.pend_valid = 1'b0;
        end
        // address moves on one cycle after the byte was taken
        if (q.rd_adv) begin
            d.rd_addr = ssrp_pkg::ssrp_next_addr(q.rd_addr,
                FIFO_READOUT_ADDR);
        end

        if (!q.cs_s) begin
            // outside a frame: partial bytes are dropped
            d.phase = ssrp_pkg::SSRP_IDLE;
            d.bitcnt = 3'h0;
            d.dout = 1'b0;
        end else if (cs_fall) begin
            d.phase = ssrp_pkg::SSRP_CMD;
            d.bitcnt = 3'h0;
            d.idle_high = q.sck_s;
        end else begin
            if (sck_rise) begin
                d.in_sh = byte_in;
                d.bitcnt = q.bitcnt + 3'h1;
                if (q.bitcnt == ssrp_pkg::LAST_BIT) begin
                    case (q.phase)
                        ssrp_pkg::SSRP_CMD: begin
                            d.wr_addr = byte_in[6:0];
                            if (byte_in[7] == ssrp_pkg::DIR_READ) begin
                                d.phase = ssrp_pkg::SSRP_RDATA;
                                d.rd_addr = byte_in[6:0];
                            end else begin
                                d.phase = ssrp_pkg::SSRP_WDATA;
                            end
                        end
                        ssrp_pkg::SSRP_WDATA: begin
                            // every data byte needs its own address
                            d.phase = ssrp_pkg::SSRP_CMD;
                            if (q.pend_valid && !push_ok) begin
                                d.overflow = 1'b1;
                            end else begin
                                d.pend_valid = 1'b1;
                                d.pend.addr = q.wr_addr;
                                d.pend.data = byte_in;
                            end
                        end
                        default: begin
                            d.phase = q.phase;
                        end
                    endcase
                end
            end
            if (sck_fall && q.phase == ssrp_pkg::SSRP_RDATA) begin
                if (q.bitcnt == 3'h0) begin
                    // a new byte starts: fetch and announce it
                    d.out_sh = i_rd_data;
                    d.dout = i_rd_data[7];
                    d.rd_req = 1'b1;
                    d.rd_adv = 1'b1;
                end else begin
                    d.out_sh = {q.out_sh[6:0], 1'b0};
                    d.dout = q.out_sh[6];
                end
            end
        end

        // a new overflow wins over a clear in the same cycle only while the flag is clear
        if (i_overflow_clr && !(d.overflow && !q.overflow)) begin
            d.overflow = 1'b0;
        end

        // pad ownership follows the phase about to be entered in three-wire, the select in four-wire
        if (i_three_wire_select) begin
            d.pad_oe_n = !(d.cs_p && d.phase == ssrp_pkg::SSRP_RDATA);
            d.sdo_oe_n = 1'b1;
        end else begin
            d.pad_oe_n = d.cs_p;
            d.sdo_oe_n = !d.cs_p;
        end
    end

    // ************************************************************
    // registers
    // ************************************************************
    always_ff @(posedge i_mclk) begin
        if (i_sys_rst) begin
            q <= '0;
            q.sdo_oe_n <= 1'b1;
        end else begin
            q <= d;
        end
    end

    // ************************************************************
    // write fifo
    // ************************************************************
    ssrp_fifo #(
        .WIDTH($bits(ssrp_pkg::ssrp_wr_t)),
        .DEPTH(WR_FIFO_DEPTH)
    ) u_wr_fifo (
        .i_mclk(i_mclk),
        .i_sys_rst(i_sys_rst),
        .i_valid(q.pend_valid),
        .i_data(q.pend),
        .o_ready(fifo_in_ready),
        .o_valid(o_wr_valid),
        .o_data(o_wr),
        .i_ready(i_wr_ready)
    );

    // ************************************************************
    // outputs
    // ************************************************************
    assign o_bidir_data_pad = q.dout;
    assign o_bidir_data_pad_oe_n = q.pad_oe_n;
    assign o_serial_out_pin = q.dout;
    assign o_serial_out_pin_oe_n = q.sdo_oe_n;
    assign o_frame_active = q.cs_s;
    assign o_clock_idle_high = q.idle_high;
    assign o_wr_overflow = q.overflow;
    assign o_rd_req = q.rd_req;
    assign o_rd_addr = q.rd_addr;

endmodule : ssrp_top

//--- test/ssrp_top_asserts.sv
// ssrp_top_asserts: port checker for the serial register port.
// assumes the host holds sck still for 8 cycles around select edges.
`timescale 1ns/1ns

module ssrp_chk #(
    parameter logic [6:0] FIFO_READOUT_ADDR = 7'h3f
) (
    // clock and reset
    input wire logic i_mclk,
    input wire logic i_sys_rst,
    // link pins
    input wire logic i_csb_n,
    input wire logic i_sck,
    input wire logic i_bidir_data_pad,
    input wire logic o_bidir_data_pad,
    input wire logic o_bidir_data_pad_oe_n,
    input wire logic o_serial_out_pin,
    input wire logic o_serial_out_pin_oe_n,
    // configuration and status
    input wire logic i_three_wire_select,
    input wire logic i_overflow_clr,
    input wire logic o_frame_active,
    input wire logic o_clock_idle_high,
    input wire logic o_wr_overflow,
    // register ports
    input wire logic o_rd_req,
    input wire logic [6:0] o_rd_addr,
    input wire logic [7:0] i_rd_data,
    input wire logic o_wr_valid,
    input wire ssrp_pkg::ssrp_wr_t o_wr,
    input wire logic i_wr_ready
);
    // ************************************************************
    // port relations
    // ************************************************************
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (i_sys_rst);

    sequence s_sel_low;
        (!i_csb_n)[*4];
    endsequence
    sequence s_idle_4w;
        (i_csb_n && !i_three_wire_select)[*5];
    endsequence
    sequence s_idle_3w;
        (i_csb_n && i_three_wire_select)[*5];
    endsequence

    property p_frame;
        s_sel_low |-> o_frame_active;
    endproperty
    a_frame: assert property (p_frame)
        else $error("frame flag low while selected");
    property p_mode;
        $rose(o_frame_active) |=> o_clock_idle_high == i_sck;
    endproperty
    a_mode: assert property (p_mode)
        else $error("clock idle level not captured");
    property p_same;
        o_serial_out_pin == o_bidir_data_pad;
    endproperty
    a_same: assert property (p_same)
        else $error("out pins differ");
    property p_3w_so;
        i_three_wire_select[*5] |-> o_serial_out_pin_oe_n;
    endproperty
    a_3w_so: assert property (p_3w_so)
        else $error("serial out driven in three-wire");
    property p_4w_idle;
        s_idle_4w |-> !o_bidir_data_pad_oe_n && o_serial_out_pin_oe_n;
    endproperty
    a_4w_idle: assert property (p_4w_idle)
        else $error("four-wire idle enables wrong");
    property p_3w_idle;
        s_idle_3w |-> o_bidir_data_pad_oe_n && !o_bidir_data_pad;
    endproperty
    a_3w_idle: assert property (p_3w_idle)
        else $error("pad driven idle in three-wire");
    property p_req;
        o_rd_req |=> !o_rd_req;
    endproperty
    a_req: assert property (p_req)
        else $error("read request longer than one cycle");
    property p_inc;
        o_rd_req && o_rd_addr != FIFO_READOUT_ADDR
            |=> o_rd_addr == $past(o_rd_addr) + 7'h01;
    endproperty
    a_inc: assert property (p_inc)
        else $error("read address did not advance");
    property p_park;
        o_rd_req && o_rd_addr == FIFO_READOUT_ADDR
            |=> o_rd_addr == FIFO_READOUT_ADDR;
    endproperty
    a_park: assert property (p_park)
        else $error("read address left the fifo register");
    property p_wr_hold;
        o_wr_valid && !i_wr_ready |=> o_wr_valid && $stable(o_wr);
    endproperty
    a_wr_hold: assert property (p_wr_hold)
        else $error("write word dropped while stalled");
endmodule : ssrp_chk

//--- test/ssrp_host_model.sv
// ssrp_host_model: serial master that frames bytes for the port.
// assumes the bench routes the returned-data pin to i_miso.
`timescale 1ns/1ns

module ssrp_host_model (
    // clock
    input wire logic i_mclk,
    // link pins
    output logic o_csb_n,
    output logic o_sck,
    output logic o_mosi,
    input wire logic i_miso
);
    logic idle_q;

    initial begin
        o_csb_n = 1'b1;
        o_sck = 1'b0;
        o_mosi = 1'b0;
        idle_q = 1'b0;
    end

    task automatic wait_n(input int n);
        repeat (n) @(negedge i_mclk);
    endtask : wait_n

    // sck idle level picks the mode and stays still over select edges
    task automatic start(input logic mode11);
        idle_q = mode11;
        o_sck = mode11;
        wait_n(8);
        o_csb_n = 1'b0;
        wait_n(8);
    endtask : start

    // msb first; data set with the fall, sampled just before the rise
    task automatic xfer(input logic [7:0] tx, input int n,
                        output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            o_sck = 1'b0;
            o_mosi = tx[i];
            wait_n(4);
            rx[i] = i_miso;
            o_sck = 1'b1;
            wait_n(4);
        end
    endtask : xfer

    task automatic stop();
        o_sck = idle_q;
        wait_n(8);
        o_csb_n = 1'b1;
        o_mosi = ~o_mosi;
        // select stays high long enough for any read after a write
        wait_n(ssrp_pkg::CSB_IDLE_CYC);
    endtask : stop
endmodule : ssrp_host_model

//--- test/test_sensor_spi_register_port.sv
// test_sensor_spi_register_port: self-checking bench for the port.
// assumes a host model on the link and a small register map model.
`timescale 1ns/1ns

module test_sensor_spi_register_port;
    localparam logic [6:0] FA = 7'h3f;
    logic mclk = 1'b0;
    logic rst;
    logic three;
    logic ovf_clr;
    logic wr_ready;
    logic csb_n, sck, mosi, pad_o, pad_oe_n, so, so_oe_n, act, idle_hi;
    logic ovf, rd_req, wr_valid;
    logic [6:0] rd_addr;
    logic [7:0] fcnt = 8'h00;
    logic [7:0] rx;
    ssrp_pkg::ssrp_wr_t wr;
    ssrp_pkg::ssrp_wr_t wq[$];
    int errors = 0;
    int n_compared = 0;
    wire logic pad_in = (pad_oe_n === 1'b0) ? pad_o : mosi;
    wire logic miso = three ? pad_in : (so_oe_n ? 1'bz : so);
    wire logic [7:0] rd_data = (rd_addr == FA) ? fcnt
                                               : {1'b0, rd_addr} ^ 8'ha5;

    initial begin
        forever #5 mclk = ~mclk;
    end

    ssrp_top #(.FIFO_READOUT_ADDR(FA)) u_dut (
        .i_mclk(mclk), .i_sys_rst(rst), .i_csb_n(csb_n), .i_sck(sck),
        .i_bidir_data_pad(pad_in), .o_bidir_data_pad(pad_o),
        .o_bidir_data_pad_oe_n(pad_oe_n), .o_serial_out_pin(so),
        .o_serial_out_pin_oe_n(so_oe_n), .i_three_wire_select(three),
        .i_overflow_clr(ovf_clr), .o_frame_active(act),
        .o_clock_idle_high(idle_hi), .o_wr_overflow(ovf),
        .o_rd_req(rd_req), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
        .o_wr_valid(wr_valid), .o_wr(wr), .i_wr_ready(wr_ready));
    ssrp_host_model u_host (.i_mclk(mclk), .o_csb_n(csb_n), .o_sck(sck),
        .o_mosi(mosi), .i_miso(miso));

    // write port sink and fifo register contents that step per read
    always @(posedge mclk) begin
        if (wr_valid && wr_ready) begin
            wq.push_back(wr);
        end
        if (rd_req && rd_addr == FA) begin
            fcnt <= fcnt + 8'h01;
        end
    end

    // ************************************************************
    // tasks
    // ************************************************************
    task automatic chk(input logic [14:0] got, input logic [14:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("BAD %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk

    task automatic end_sim();
        if (errors == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : end_sim

    task automatic wr_pair(input logic [6:0] a, input logic [7:0] d);
        u_host.xfer({ssrp_pkg::DIR_WRITE, a}, 8, rx);
        u_host.xfer(d, 8, rx);
    endtask : wr_pair

    task automatic chk_wr(input logic [6:0] a, input logic [7:0] d);
        for (int i = 0; i < 40 && wq.size() == 0; i++) begin
            @(negedge mclk);
        end
        chk((wq.size() > 0) ? wq.pop_front() : 15'hxxxx, {a, d});
    endtask : chk_wr

    // expected address steps by one and parks at the fifo register
    task automatic rd_chk(input logic [6:0] a, input int n);
        logic [6:0] e;
        logic [7:0] base;
        e = a;
        base = fcnt;
        u_host.xfer({ssrp_pkg::DIR_READ, a}, 8, rx);
        for (int i = 0; i < n; i++) begin
            u_host.xfer(8'h55, 8, rx);
            chk(15'(rx), 15'((e == FA) ? base : {1'b0, e} ^ 8'ha5));
            base = (e == FA) ? base + 8'h01 : base;
            e = (e == FA) ? e : e + 7'h01;
        end
    endtask : rd_chk

    // ************************************************************
    // scenarios
    // ************************************************************
    initial begin
        rst = 1'b1;
        three = 1'b0;
        ovf_clr = 1'b0;
        wr_ready = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        repeat (4) @(negedge mclk);
        chk(15'({pad_oe_n, so_oe_n}), 15'h0001);
        u_host.start(1'b0);
        wr_pair(7'h12, 8'h05);
        u_host.stop();
        chk(15'(idle_hi), 15'h0000);
        chk_wr(7'h12, 8'h05);
        u_host.start(1'b1);
        u_host.xfer(8'h0f, 4, rx);
        u_host.stop();
        u_host.start(1'b1);
        wr_pair(7'h01, 8'haa);
        u_host.stop();
        chk(15'(idle_hi), 15'h0001);
        chk_wr(7'h01, 8'haa);
        wr_ready = 1'b0;
        u_host.start(1'b0);
        for (int i = 0; i < 12; i++) begin
            wr_pair(7'(i), 8'h30 + 8'(i));
        end
        u_host.stop();
        chk(15'(ovf), 15'h0001);
        wr_ready = 1'b1;
        for (int i = 0; i < 8; i++) begin
            chk_wr(7'(i), 8'h30 + 8'(i));
        end
        repeat (20) @(negedge mclk);
        wq.delete();
        ovf_clr = 1'b1;
        @(negedge mclk);
        ovf_clr = 1'b0;
        @(negedge mclk);
        chk(15'(ovf), 15'h0000);
        u_host.start(1'b0);
        rd_chk(7'h3d, 4);
        u_host.stop();
        three = 1'b1;
        u_host.start(1'b1);
        rd_chk(FA, 3);
        u_host.stop();
        three = 1'b0;
        u_host.start(1'b0);
        wr_pair(7'h22, 8'h77);
        rd_chk(7'h10, 2);
        u_host.stop();
        chk_wr(7'h22, 8'h77);
        end_sim();
    end

    initial begin
        #300000;
        errors++;
        end_sim();
    end
endmodule : test_sensor_spi_register_port

bind ssrp_top ssrp_chk #(.FIFO_READOUT_ADDR(FIFO_READOUT_ADDR)) u_chk (.*);
